// ---- include/lpdp_if.sv ----
// command, address, clock gate and clock-run wires between the two ends
`timescale 1ns/1ps
interface lpdp_if;
  import lpdp_pkg::*;
  logic ck_run;
  logic cke;
  logic [3:0] cmd;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  modport ctrl (output ck_run, output cke, output cmd, output ba,
                output addr);
  modport mem (input ck_run, input cke, input cmd, input ba, input addr);
endinterface : lpdp_if

// ---- include/lpdp_pkg.sv ----
// shared constants, command codes and types for the low-power dram link
// Contract
// [R01] auto precharge bit closes bank after burst
// [R02] auto precharge applies to one command only
// [R03] controller waits precharge time after auto precharge
// [R04] all rows refreshed within 64ms window
// [R05] refresh spaced at window over rows
// [R06] one auto refresh command, one refresh
// [R07] refresh with clock gate low enters self refresh
// [R08] self refresh ignores inputs; clock may stop
// [R09] clock gate low for at least refresh cycle
// [R10] stable clock, then exit delay before command
// [R11] extra auto refresh after self refresh exit
// [R12] clock gate low while idle enters power-down
// [R13] power-down treats other inputs as don't-care
// [R14] power-down minimum time, ends for refresh
// [R15] power-down exit on gate high with nop
// [R16] burst stop with gate low: deepest sleep
// [R17] deepest sleep loses data and mode settings
// [R18] deepest sleep exit: 200us nops, re-init
// [R19] clock stop only when quiet, gate high
// [R20] one nop after clock restart before access
// [R21] precharged bank needs activate before access
// [R22] track open banks and power state
package lpdp_pkg;
  localparam int CLK_NS = 40;
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int NBANK = 4;
  localparam int AP_SEL_BIT = 10;
  localparam int TMR_W = 16;
  localparam int BURST_LEN = 4;
  localparam int T_ROW_PRE_NS = 18;
  localparam int T_REF_CYCLE_NS = 72;
  localparam int T_SR_EXIT_NS = 112;
  localparam int T_PD_EXIT_NS = 25;
  localparam int T_GATE_LOW_NS = 40;
  localparam int T_ACT_ACC_NS = 18;
  localparam int T_MODE_SET_NS = 20;
  localparam int REF_WINDOW_NS = 64000000;
  localparam int ROWS = 8192;
  localparam int DEEP_NOP_NS = 200000;
  localparam int CSTOP_NOP_CYC = 1;
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT_MODE = 2'h2;
  // {chip select, row strobe, column strobe, write enable}, all active low
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_max

  function automatic logic [NBANK-1:0] bank_bit(input logic [BA_W-1:0] ba);
    return NBANK'(1) << ba;
  endfunction : bank_bit

  function automatic logic is_nop(input logic [3:0] cmd);
    return cmd[3] || (cmd == CMD_NOP);
  endfunction : is_nop

  localparam int RP_CYC = cyc_min(T_ROW_PRE_NS);
  localparam int RFC_CYC = cyc_min(T_REF_CYCLE_NS);
  localparam int XS_CYC = cyc_min(T_SR_EXIT_NS);
  localparam int XP_CYC = cyc_min(T_PD_EXIT_NS);
  localparam int GATE_LOW_CYC = cyc_min(T_GATE_LOW_NS);
  localparam int RCD_CYC = cyc_min(T_ACT_ACC_NS);
  localparam int MRD_CYC = cyc_min(T_MODE_SET_NS);
  localparam int REFI_CYC = cyc_max(REF_WINDOW_NS / ROWS);
  localparam int DEEP_NOP_CYC = cyc_min(DEEP_NOP_NS);

  typedef enum logic [2:0] {
    PWR_NORMAL, PWR_PDN_PRE, PWR_PDN_ACT, PWR_SELF_REF, PWR_DEEP,
    PWR_CLK_STOP
  } lpdp_pwr_t;

  typedef enum logic [3:0] {
    OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_MRS, OP_PDN, OP_SREF, OP_DEEP,
    OP_CSTOP, OP_WAKE
  } lpdp_op_t;

  typedef enum logic [2:0] {
    CS_RUN, CS_PDN, CS_SREF, CS_DEEP, CS_CSTOP, CS_EXIT
  } lpdp_cstate_t;
endpackage : lpdp_pkg

// ---- rtl/lpdp_ctrl.sv ----
// controller end: request sequencing, refresh scheduling, power exits
`timescale 1ns/1ps
module lpdp_ctrl import lpdp_pkg::*; #(
  parameter int REFI = REFI_CYC,
  parameter int DEEP_WAIT = DEEP_NOP_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire lpdp_op_t req_op,
  input wire logic [BA_W-1:0] req_bank,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_ap,
  output logic req_ready,
  output lpdp_cstate_t ctrl_state,
  output logic refresh_issued,
  output logic need_init,
  lpdp_if.ctrl bus
);
  lpdp_cstate_t st_q, st_d;
  logic cke_q, cke_d;
  logic ck_run_q, ck_run_d;
  logic [3:0] cmd_q, cmd_d;
  logic [BA_W-1:0] ba_q, ba_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [NBANK-1:0] open_q, open_d;
  logic [NBANK-1:0] blk_load;
  logic [7:0] blk_val;
  logic [7:0] blk_q [NBANK];
  logic [3:0] bst_q;
  logic bst_load;
  logic [TMR_W-1:0] ref_cnt_q;
  logic ref_due_q;
  logic ref_clr;
  logic sr_exit;
  logic init_set;
  logic wt_load;
  logic [TMR_W-1:0] wt_val;
  logic wt_done;
  logic blk_zero;

  always_comb
  begin
    blk_zero = 1'b1;
    for (int i = 0; i < NBANK; i++)
      blk_zero = blk_zero && (blk_q[i] == 8'h0);
  end

  wire all_idle = open_q == '0;
  wire quiet = bst_q == 4'h0 && blk_zero;
  wire in_run = st_q == CS_RUN && wt_done;
  wire do_ref = in_run && ref_due_q && quiet; // [R04]
  wire ref_pre = do_ref && !all_idle;
  wire ref_now = do_ref && all_idle;
  wire bank_free = blk_q[req_bank] == 8'h0; // [R03]
  wire is_rw = req_op == OP_READ || req_op == OP_WRITE;
  wire wake = req_op == OP_WAKE;
  wire run_ok =
    (req_op == OP_ACT) ? bank_free && !open_q[req_bank] :
    is_rw ? bank_free && open_q[req_bank] : // [R21]
    (req_op == OP_PRE) ? bank_free :
    (req_op == OP_MRS || req_op == OP_SREF) ? all_idle && quiet :
    (req_op == OP_DEEP) ? all_idle && quiet : // [R16]
    (req_op == OP_PDN) ? bst_q == 4'h0 : // [R12]
    (req_op == OP_CSTOP) ? quiet && cke_q : // [R19]
    wake;
  wire sleep_ok = wt_done && wake &&
    (st_q == CS_PDN || st_q == CS_DEEP || st_q == CS_CSTOP ||
     (st_q == CS_SREF && ck_run_q)); // [R10]
  assign req_ready = (in_run && !do_ref && run_ok) || sleep_ok;
  wire take = req_valid && req_ready;
  wire [ADDR_W-1:0] ap_addr = ADDR_W'(1) << AP_SEL_BIT;

  always_comb
  begin
    st_d = st_q;
    cke_d = cke_q;
    ck_run_d = ck_run_q;
    cmd_d = CMD_NOP;
    ba_d = ba_q;
    addr_d = addr_q;
    open_d = open_q;
    blk_load = '0;
    blk_val = 8'h0;
    bst_load = 1'b0;
    ref_clr = 1'b0;
    sr_exit = 1'b0;
    init_set = 1'b0;
    wt_load = 1'b0;
    wt_val = '0;
    case (st_q)
      CS_RUN:
        if (ref_pre)
        begin
          cmd_d = CMD_PRE;
          addr_d = ap_addr;
          open_d = '0;
          blk_load = {NBANK{1'b1}};
          blk_val = 8'(RP_CYC);
        end
        else if (ref_now)
        begin
          cmd_d = CMD_REF; // [R06]
          ref_clr = 1'b1;
          wt_load = 1'b1;
          wt_val = TMR_W'(RFC_CYC);
        end
        else if (take)
        begin
          ba_d = req_bank;
          addr_d = req_addr;
          case (req_op)
            OP_ACT:
            begin
              cmd_d = CMD_ACT;
              open_d = open_q | bank_bit(req_bank);
              wt_load = 1'b1;
              wt_val = TMR_W'(RCD_CYC);
            end
            OP_READ, OP_WRITE:
            begin
              cmd_d = (req_op == OP_READ) ? CMD_READ : CMD_WRITE;
              addr_d[AP_SEL_BIT] = req_ap; // [R02]
              bst_load = 1'b1;
              if (req_ap)
              begin
                open_d = open_q & ~bank_bit(req_bank); // [R01]
                blk_load = bank_bit(req_bank); // [R03]
                blk_val = 8'(RP_CYC + BURST_LEN / 2); // [R03]
              end
            end
            OP_PRE:
            begin
              cmd_d = CMD_PRE;
              addr_d[AP_SEL_BIT] = req_ap;
              open_d = req_ap ? '0 : open_q & ~bank_bit(req_bank);
              blk_load = req_ap ? {NBANK{1'b1}} : bank_bit(req_bank);
              blk_val = 8'(RP_CYC);
            end
            OP_MRS:
            begin
              cmd_d = CMD_MRS;
              wt_load = 1'b1;
              wt_val = TMR_W'(MRD_CYC);
            end
            OP_PDN:
            begin
              cke_d = 1'b0;
              st_d = CS_PDN;
              wt_load = 1'b1;
              wt_val = TMR_W'(GATE_LOW_CYC); // [R14]
            end
            OP_SREF:
            begin
              cmd_d = CMD_REF;
              cke_d = 1'b0; // [R07]
              st_d = CS_SREF;
              wt_load = 1'b1;
              wt_val = TMR_W'(RFC_CYC); // [R09]
            end
            OP_DEEP:
            begin
              cmd_d = CMD_BST;
              cke_d = 1'b0; // [R16]
              st_d = CS_DEEP;
            end
            OP_CSTOP:
            begin
              ck_run_d = 1'b0; // [R19]
              st_d = CS_CSTOP;
            end
            default:
              cmd_d = CMD_NOP;
          endcase
        end
      CS_PDN:
        if (wt_done && (take || ref_due_q))
        begin
          cke_d = 1'b1; // [R14] [R15]
          st_d = CS_EXIT;
          wt_load = 1'b1;
          wt_val = TMR_W'(XP_CYC); // [R15]
        end
      CS_SREF:
        if (req_valid && wake && wt_done && !ck_run_q)
          ck_run_d = 1'b1; // [R10]
        else if (take)
        begin
          cke_d = 1'b1;
          st_d = CS_EXIT;
          sr_exit = 1'b1;
          wt_load = 1'b1;
          wt_val = TMR_W'(XS_CYC); // [R10]
        end
        else if (!(req_valid && wake && wt_done) && cmd_q != CMD_REF)
          ck_run_d = 1'b0; // [R08]
      CS_DEEP:
        if (take)
        begin
          cke_d = 1'b1; // [R18]
          st_d = CS_EXIT;
          init_set = 1'b1;
          wt_load = 1'b1;
          wt_val = TMR_W'(DEEP_WAIT); // [R18]
        end
      CS_CSTOP:
        if (take)
        begin
          ck_run_d = 1'b1;
          st_d = CS_EXIT;
          wt_load = 1'b1;
          wt_val = TMR_W'(CSTOP_NOP_CYC); // [R20]
        end
      CS_EXIT:
        if (wt_done)
          st_d = CS_RUN;
      default:
        st_d = CS_RUN;
    endcase
  end

  lpdp_timer #(.W(TMR_W)) u_wait_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(wt_load),
    .value(wt_val),
    .done(wt_done)
  );

  wire ref_tick = ref_cnt_q == '0;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= CS_RUN;
      cke_q <= 1'b1;
      ck_run_q <= 1'b1;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      addr_q <= '0;
      open_q <= '0;
      bst_q <= 4'h0;
    end
    else
    begin
      st_q <= st_d;
      cke_q <= cke_d;
      ck_run_q <= ck_run_d;
      cmd_q <= cmd_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
      open_q <= open_d;
      bst_q <= bst_load ? 4'((BURST_LEN / 2)) :
        ((bst_q != 4'h0) ? bst_q - 4'h1 : 4'h0);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      for (int i = 0; i < NBANK; i++)
        blk_q[i] <= 8'h0;
    else
      for (int i = 0; i < NBANK; i++)
        blk_q[i] <= blk_load[i] ? blk_val :
          ((blk_q[i] != 8'h0) ? blk_q[i] - 8'h1 : 8'h0);
  end

  // refresh interval counter; a new due or a self refresh exit beats clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_cnt_q <= '0;
      ref_due_q <= 1'b0;
      refresh_issued <= 1'b0;
      need_init <= 1'b0;
    end
    else
    begin
      ref_cnt_q <= ref_tick ? TMR_W'(REFI - 1) : ref_cnt_q - TMR_W'(1); // [R05]
      ref_due_q <= ref_tick || sr_exit || (ref_due_q && !ref_clr); // [R11]
      refresh_issued <= ref_clr;
      need_init <= init_set || (need_init && !(take && req_op == OP_MRS));
    end
  end

  assign ctrl_state = st_q;
  assign bus.cke = cke_q;
  assign bus.ck_run = ck_run_q;
  assign bus.cmd = cmd_q;
  assign bus.ba = ba_q;
  assign bus.addr = addr_q;
endmodule : lpdp_ctrl

// ---- rtl/lpdp_mem.sv ----
// memory end: command decode, bank tracking and power states
`timescale 1ns/1ps
module lpdp_mem import lpdp_pkg::*; #(
  parameter int SR_TICK_CYC = REFI_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  lpdp_if.mem bus,
  output lpdp_pwr_t power_state,
  output logic [NBANK-1:0] bank_open,
  output logic [ADDR_W-1:0] mode_cfg,
  output logic [ADDR_W-1:0] ext_mode_cfg,
  output logic refresh_pulse,
  output logic self_refresh_tick,
  output logic access_error
);
  lpdp_pwr_t st_q, st_d;
  logic cke_prev_q;
  logic [3:0] bst_q;
  logic ap_q;
  logic [BA_W-1:0] ap_bank_q;
  logic sr_done;

  // commands count only in normal state with the gate high on both edges
  wire live = st_q == PWR_NORMAL && cke_prev_q && bus.cke && bus.ck_run;
  wire enter = st_q == PWR_NORMAL && cke_prev_q && !bus.cke;
  wire busy = bst_q != 4'h0;
  wire cmd_act = live && bus.cmd == CMD_ACT;
  wire cmd_rw = live && (bus.cmd == CMD_READ || bus.cmd == CMD_WRITE);
  wire cmd_pre = live && bus.cmd == CMD_PRE;
  wire cmd_ref = live && bus.cmd == CMD_REF;
  wire cmd_mrs = live && bus.cmd == CMD_MRS;
  wire go_deep = enter && bus.cmd == CMD_BST && bank_open == '0 && !busy;
  wire [NBANK-1:0] sel = bank_bit(bus.ba);
  wire [NBANK-1:0] pre_mask = cmd_pre ?
    (bus.addr[AP_SEL_BIT] ? {NBANK{1'b1}} : sel) : '0;
  // burst end, or a new access cutting it short, closes the bank
  wire [NBANK-1:0] ap_mask = (ap_q && (bst_q == 4'h1 || cmd_rw)) ?
    bank_bit(ap_bank_q) : '0; // [R01]
  wire [NBANK-1:0] act_mask = cmd_act ? sel : '0;
  wire [NBANK-1:0] open_d = go_deep ? '0 :
    (bank_open & ~pre_mask & ~ap_mask) | act_mask; // [R21] [R22]
  wire sr_load = (st_d == PWR_SELF_REF && st_q != PWR_SELF_REF) ||
    (st_q == PWR_SELF_REF && sr_done);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      PWR_NORMAL:
        if (enter && bus.cmd == CMD_REF)
          st_d = PWR_SELF_REF; // [R07]
        else if (go_deep)
          st_d = PWR_DEEP; // [R16]
        else if (enter && !busy)
          st_d = (bank_open != '0) ? PWR_PDN_ACT : PWR_PDN_PRE; // [R12]
        else if (cke_prev_q && bus.cke && !bus.ck_run)
          st_d = PWR_CLK_STOP;
      PWR_PDN_PRE, PWR_PDN_ACT:
        if (bus.cke && is_nop(bus.cmd))
          st_d = PWR_NORMAL; // [R13] [R15]
      PWR_SELF_REF, PWR_DEEP:
        if (bus.cke)
          st_d = PWR_NORMAL; // [R08]
      PWR_CLK_STOP:
        if (bus.ck_run)
          st_d = PWR_NORMAL;
      default:
        st_d = PWR_NORMAL;
    endcase
  end

  lpdp_timer #(.W(TMR_W)) u_sr_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(sr_load),
    .value(TMR_W'(SR_TICK_CYC)),
    .done(sr_done)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= PWR_NORMAL;
      cke_prev_q <= 1'b1;
      bank_open <= '0;
      bst_q <= 4'h0;
      ap_q <= 1'b0;
      ap_bank_q <= '0;
      refresh_pulse <= 1'b0;
      self_refresh_tick <= 1'b0;
      access_error <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cke_prev_q <= bus.cke;
      bank_open <= open_d;
      bst_q <= cmd_rw ? 4'((BURST_LEN / 2)) : (busy ? bst_q - 4'h1 : 4'h0);
      ap_q <= cmd_rw ? bus.addr[AP_SEL_BIT] : (ap_q && bst_q != 4'h1); // [R02]
      ap_bank_q <= cmd_rw ? bus.ba : ap_bank_q;
      refresh_pulse <= cmd_ref; // [R06]
      self_refresh_tick <= st_q == PWR_SELF_REF && sr_done; // [R07]
      access_error <= cmd_rw && !bank_open[bus.ba]; // [R21]
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_cfg <= '0;
      ext_mode_cfg <= '0;
    end
    else if (go_deep)
    begin
      mode_cfg <= '0; // [R17]
      ext_mode_cfg <= '0; // [R17]
    end
    else if (cmd_mrs && bus.ba == BA_MODE)
      mode_cfg <= bus.addr;
    else if (cmd_mrs && bus.ba == BA_EXT_MODE)
      ext_mode_cfg <= bus.addr;
  end

  assign power_state = st_q;
endmodule : lpdp_mem

// ---- rtl/lpdp_timer.sv ----
// loadable down counter with a done level
`timescale 1ns/1ps
module lpdp_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_q;

  assign done = (cnt_q == '0);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else if (load)
      cnt_q <= value;
    else if (!done)
      cnt_q <= cnt_q - W'(1);
  end
endmodule : lpdp_timer

// ---- sim/lpddr_refresh_power_states_tb.sv ----
// bench: controller and memory joined, second memory driven directly
`timescale 1ns/1ps
module lpddr_refresh_power_states_tb import lpdp_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  lpdp_op_t req_op = OP_ACT;
  logic [BA_W-1:0] req_bank = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic req_ap = 1'b0;
  logic req_ready, refresh_issued, need_init, refresh_pulse, sr_tick;
  logic err, err2;
  lpdp_cstate_t ctrl_state;
  lpdp_pwr_t power_state, pwr2;
  logic [NBANK-1:0] bank_open, bank2;
  logic [ADDR_W-1:0] mode_cfg, ext_mode_cfg;
  logic [3:0] last_cmd;
  logic last_a10;
  int miscompares = 0;
  int checked = 0;
  int n_bus = 0, n_pulse = 0, n_tick = 0, n_err = 0, n_cyc = 0, n_err0 = 0;

  always #20 clk = ~clk;

  lpdp_if bus_if();
  lpdp_if bus2();
  lpdp_ctrl #(.REFI(40), .DEEP_WAIT(20)) i_lpdp_ctrl (.clk(clk),
    .reset_n(reset_n), .req_valid(req_valid), .req_op(req_op),
    .req_bank(req_bank), .req_addr(req_addr), .req_ap(req_ap),
    .req_ready(req_ready), .ctrl_state(ctrl_state),
    .refresh_issued(refresh_issued), .need_init(need_init), .bus(bus_if));
  lpdp_mem #(.SR_TICK_CYC(10)) i_lpdp_mem (.clk(clk), .reset_n(reset_n),
    .bus(bus_if), .power_state(power_state), .bank_open(bank_open),
    .mode_cfg(mode_cfg), .ext_mode_cfg(ext_mode_cfg),
    .refresh_pulse(refresh_pulse), .self_refresh_tick(sr_tick),
    .access_error(err));
  lpdp_mem #(.SR_TICK_CYC(10)) i_lpdp_mem2 (.clk(clk), .reset_n(reset_n),
    .bus(bus2), .power_state(pwr2), .bank_open(bank2), .mode_cfg(),
    .ext_mode_cfg(), .refresh_pulse(), .self_refresh_tick(),
    .access_error(err2));
  lpdp_properties #(.DEEP_WAIT(20)) i_lpdp_properties (.clk(clk),
    .reset_n(reset_n), .ck_run(bus_if.ck_run), .cke(bus_if.cke),
    .cmd(bus_if.cmd), .ba(bus_if.ba), .addr(bus_if.addr));

  always @(posedge clk)
  begin
    n_cyc++;
    n_bus += int'(bus_if.cmd === CMD_REF && bus_if.cke === 1'b1);
    n_pulse += int'(refresh_pulse === 1'b1);
    n_tick += int'(sr_tick === 1'b1);
    n_err += int'(err2 === 1'b1);
    n_err0 += int'(err === 1'b1);
  end

  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tmo;
    miscompares++;
    $display("[FAIL] wait expected done seen timeout");
    end_of_test();
  endtask : tmo

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic req(input lpdp_op_t op, input logic [1:0] b,
                     input logic [12:0] a, input logic ap);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req_op = op;
    req_bank = b;
    req_addr = a;
    req_ap = ap;
    #1;
    while (req_ready !== 1'b1)
    begin
      if (++n > 300)
        tmo();
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    req_valid = 1'b0;
    last_cmd = bus_if.cmd;
    last_a10 = bus_if.addr[AP_SEL_BIT];
  endtask : req

  task automatic wait_pwr(input lpdp_pwr_t e);
    int n;
    n = 0;
    while (power_state !== e)
    begin
      if (++n > 100)
        tmo();
      @(negedge clk);
    end
    chk("power_state", 16'(power_state), 16'(e));
  endtask : wait_pwr

  // start each scenario except t_dev just after a scheduled refresh
  task automatic sync_ref;
    int n;
    n = 0;
    while (refresh_issued !== 1'b1)
    begin
      if (++n > 200)
        tmo();
      @(negedge clk);
    end
    @(negedge clk);
  endtask : sync_ref

  task automatic drv(input logic [3:0] c, input logic k);
    @(negedge clk);
    bus2.cmd = c;
    bus2.cke = k;
  endtask : drv

  task automatic t_ap;
    sync_ref();
    req(OP_ACT, 2'h1, 13'h0123, 1'b0);
    req(OP_READ, 2'h1, 13'h0008, 1'b1);
    chk("read cmd", 16'(last_cmd), 16'(CMD_READ));
    chk("ap bit", 16'(last_a10), 16'h0001);
    cyc(6);
    chk("bank closed", 16'(bank_open), 16'h0000);
    req(OP_ACT, 2'h1, 13'h0123, 1'b0);
    req(OP_READ, 2'h1, 13'h0008, 1'b0);
    chk("ap bit", 16'(last_a10), 16'h0000);
    cyc(6);
    chk("bank held", 16'(bank_open), 16'h0002);
    req(OP_PRE, 2'h1, 13'h0000, 1'b0);
    $display("t_ap done");
  endtask : t_ap

  task automatic t_ref;
    int a, b, c;
    sync_ref();
    a = n_bus;
    b = n_pulse;
    c = n_cyc;
    repeat (10) sync_ref();
    chk("refresh count", 16'(n_bus - a), 16'h000A);
    chk("refresh pulses", 16'(n_pulse - b), 16'h000A);
    chk("spacing", 16'(n_cyc - c <= 410), 16'h0001);
    $display("t_ref done");
  endtask : t_ref

  task automatic t_sref;
    int a, b;
    sync_ref();
    a = n_bus;
    req(OP_SREF, 2'h0, 13'h0000, 1'b0);
    chk("sref cmd", 16'(last_cmd), 16'(CMD_REF));
    chk("sref gate", 16'(bus_if.cke), 16'h0000);
    wait_pwr(PWR_SELF_REF);
    b = n_tick;
    cyc(15);
    chk("internal tick", 16'(n_tick > b), 16'h0001);
    chk("clock stopped", 16'(bus_if.ck_run), 16'h0000);
    chk("ctrl state", 16'(ctrl_state), 16'(CS_SREF));
    req(OP_WAKE, 2'h0, 13'h0000, 1'b0);
    wait_pwr(PWR_NORMAL);
    cyc(8);
    chk("extra refresh", 16'(n_bus - a >= 1), 16'h0001);
    $display("t_sref done");
  endtask : t_sref

  task automatic t_pdn;
    sync_ref();
    req(OP_ACT, 2'h2, 13'h0040, 1'b0);
    req(OP_PDN, 2'h0, 13'h0000, 1'b0);
    wait_pwr(PWR_PDN_ACT);
    req(OP_WAKE, 2'h0, 13'h0000, 1'b0);
    wait_pwr(PWR_NORMAL);
    chk("row kept", 16'(bank_open), 16'h0004);
    req(OP_PRE, 2'h2, 13'h0000, 1'b0);
    req(OP_PDN, 2'h0, 13'h0000, 1'b0);
    wait_pwr(PWR_PDN_PRE);
    wait_pwr(PWR_NORMAL);
    $display("t_pdn done");
  endtask : t_pdn

  task automatic t_deep;
    sync_ref();
    req(OP_MRS, BA_MODE, 13'h0032, 1'b0);
    req(OP_MRS, BA_EXT_MODE, 13'h0020, 1'b0);
    cyc(2);
    chk("mode", 16'(mode_cfg), 16'h0032);
    chk("ext mode", 16'(ext_mode_cfg), 16'h0020);
    req(OP_DEEP, 2'h0, 13'h0000, 1'b0);
    chk("deep cmd", 16'(last_cmd), 16'(CMD_BST));
    wait_pwr(PWR_DEEP);
    chk("mode lost", 16'(mode_cfg | ext_mode_cfg), 16'h0000);
    req(OP_WAKE, 2'h0, 13'h0000, 1'b0);
    wait_pwr(PWR_NORMAL);
    cyc(22);
    chk("init flag", 16'(need_init), 16'h0001);
    req(OP_MRS, BA_MODE, 13'h0032, 1'b0);
    cyc(2);
    chk("init flag", 16'(need_init), 16'h0000);
    $display("t_deep done");
  endtask : t_deep

  task automatic t_cstop;
    sync_ref();
    req(OP_ACT, 2'h0, 13'h0010, 1'b0);
    cyc(2);
    req(OP_CSTOP, 2'h0, 13'h0000, 1'b0);
    chk("clock run", 16'(bus_if.ck_run), 16'h0000);
    wait_pwr(PWR_CLK_STOP);
    req(OP_WAKE, 2'h0, 13'h0000, 1'b0);
    wait_pwr(PWR_NORMAL);
    chk("row kept", 16'(bank_open), 16'h0001);
    req(OP_PRE, 2'h0, 13'h0000, 1'b1);
    $display("t_cstop done");
  endtask : t_cstop

  task automatic t_dev;
    drv(CMD_READ, 1'b1);
    drv(CMD_NOP, 1'b1);
    cyc(2);
    chk("closed access", 16'(n_err), 16'h0001);
    chk("access error", 16'(n_err0), 16'h0000);
    drv(CMD_NOP, 1'b0);
    cyc(2);
    chk("pdn", 16'(pwr2), 16'(PWR_PDN_PRE));
    drv(CMD_ACT, 1'b1);
    drv(CMD_NOP, 1'b1);
    cyc(2);
    chk("pdn ignore", 16'(bank2), 16'h0000);
    chk("pdn exit", 16'(pwr2), 16'(PWR_NORMAL));
    drv(CMD_REF, 1'b0);
    drv(CMD_ACT, 1'b0);
    drv(CMD_NOP, 1'b0);
    cyc(1);
    chk("sref", 16'(pwr2), 16'(PWR_SELF_REF));
    chk("sref ignore", 16'(bank2), 16'h0000);
    drv(CMD_NOP, 1'b1);
    cyc(6);
    chk("sref exit", 16'(pwr2), 16'(PWR_NORMAL));
    $display("t_dev done");
  endtask : t_dev

  initial
  begin
    bus2.ck_run = 1'b1;
    bus2.cke = 1'b1;
    bus2.cmd = CMD_NOP;
    bus2.ba = 2'h3;
    bus2.addr = 13'h0000;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_ap();
    t_ref();
    t_sref();
    t_pdn();
    t_deep();
    t_cstop();
    t_dev();
    end_of_test();
  end
endmodule : lpddr_refresh_power_states_tb

// ---- sim/lpdp_properties.sv ----
// bus-level checks on the link between controller and memory ends
`timescale 1ns/1ps
module lpdp_properties import lpdp_pkg::*; #(
  parameter int DEEP_WAIT = DEEP_NOP_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ck_run,
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr
);
  logic cke_q;
  logic sref_q;
  logic deep_q;
  logic [15:0] wait_q;
  wire nop_w = cmd[3] || (cmd == CMD_NOP);
  wire rw_w = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  wire go_sref_w = cke_q && !cke && (cmd == CMD_REF);
  wire go_deep_w = cke_q && !cke && (cmd == CMD_BST);
  // deep-exit nop window counter
  wire [15:0] wait_d = (cke && deep_q) ? 16'(DEEP_WAIT - 1) :
                       (wait_q != 16'h0000) ? wait_q - 16'h0001 : wait_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cke_q <= 1'b1;
      sref_q <= 1'b0;
      deep_q <= 1'b0;
      wait_q <= 16'h0000;
    end
    else
    begin
      cke_q <= cke;
      sref_q <= go_sref_w || (sref_q && !cke);
      deep_q <= go_deep_w || (deep_q && !cke);
      wait_q <= wait_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_sref_run;
    go_sref_w |-> ck_run ##1 ck_run;
  endproperty
  a_sref_run: assert property (p_sref_run)
    else $error("clock stopped too soon after self refresh entry");
  property p_sref_low;
    go_sref_w |=> !cke;
  endproperty
  a_sref_low: assert property (p_sref_low)
    else $error("self refresh left too early");
  property p_sref_exit;
    $rose(cke) && sref_q |-> nop_w [*3];
  endproperty
  a_sref_exit: assert property (p_sref_exit)
    else $error("command inside self refresh exit delay");
  property p_extra_ref;
    $rose(cke) && sref_q |-> ##[1:12] (cmd == CMD_REF && cke);
  endproperty
  a_extra_ref: assert property (p_extra_ref)
    else $error("no refresh after self refresh exit");
  property p_pd_exit;
    $rose(cke) |-> nop_w;
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("clock gate raised without nop");
  property p_deep_nop;
    (cke && deep_q) || (wait_q != 16'h0000) |-> nop_w;
  endproperty
  a_deep_nop: assert property (p_deep_nop)
    else $error("command inside deep sleep exit wait");
  property p_cstop_gate;
    $fell(ck_run) |-> cke || sref_q;
  endproperty
  a_cstop_gate: assert property (p_cstop_gate)
    else $error("clock stopped with gate low");
  property p_restart_nop;
    $rose(ck_run) |-> nop_w;
  endproperty
  a_restart_nop: assert property (p_restart_nop)
    else $error("access on clock restart cycle");
  property p_ref_once;
    cmd == CMD_REF && cke && cke_q |=> nop_w;
  endproperty
  a_ref_once: assert property (p_ref_once)
    else $error("command right after refresh");
  property p_ap_block;
    rw_w && addr[AP_SEL_BIT] && cke |=>
      !(cmd == CMD_ACT && ba == $past(ba));
  endproperty
  a_ap_block: assert property (p_ap_block)
    else $error("activate during auto precharge");
endmodule : lpdp_properties
